// [pkg/tmc_pkg.sv]
package tmc_pkg;

    // Register byte addresses (one aligned word each)
    localparam logic [11:0] ADDR_STATUS_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_COUNT_HIGH = 12'h004;
    localparam logic [11:0] ADDR_COUNT_LOW = 12'h008;
    localparam logic [11:0] ADDR_WRAP_HIGH = 12'h00c;
    localparam logic [11:0] ADDR_WRAP_LOW = 12'h010;

    // Status/control field positions
    localparam int BIT_OVF = 7;
    localparam int BIT_OVIE = 6;
    localparam int BIT_CAS = 5;
    localparam int BIT_CLKS_HI = 4;
    localparam int BIT_CLKS_LO = 3;
    localparam int BIT_PS_HI = 2;
    localparam int BIT_PS_LO = 0;

    // Clock source codes
    localparam logic [1:0] CLKS_OFF = 2'h0;
    localparam logic [1:0] CLKS_BUS = 2'h1;
    localparam logic [1:0] CLKS_FIXED = 2'h2;
    localparam logic [1:0] CLKS_EXT = 2'h3;

    // Reset values, all-ones wrap limit and count step
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] WRAP_RESET = 16'h0000;
    localparam logic [15:0] WRAP_ALL_ONES = 16'hffff;
    localparam logic [15:0] COUNT_ONE = 16'h0001;

    typedef enum logic [1:0] {
        LATCH_IDLE,
        LATCH_HIGH_READ,
        LATCH_LOW_READ
    } tmc_latch_type;

    typedef struct packed {
        logic ovf;
        logic ovf_armed;
        logic ovie;
        logic cas;
        logic [1:0] clks;
        logic [2:0] ps;
        logic [15:0] count;
        logic down;
        logic [15:0] wrap;
        logic [7:0] wrap_hold;
        logic wrap_half;
        tmc_latch_type latch;
        logic [15:0] latch_buf;
        logic [6:0] pre;
        logic [1:0] ext_sync;
        logic ext_prev;
        logic [1:0] fix_sync;
        logic fix_prev;
        logic [31:0] prdata;
        logic pslverr;
        logic ack;
    } tmc_state_type;

    // Outputs to channel logic
    typedef struct packed {
        logic [15:0] count;
        logic down;
        logic tick;
        logic overflow;
    } tmc_chan_type;

endpackage : tmc_pkg

// [rtl/tmc_core.sv]
`timescale 1ns/1ps
// What this block does
// - Up mode: flag set when counter wraps to zero after wrap limit
// - Center mode: flag set stepping below the wrap limit
// - Flag clears only on read-while-set then write zero
// - Overflow between read and clearing write restarts the clear sequence
// - Reset clears flag; writing one to flag does nothing
// - Bit 6 enables interrupt request while flag is one
// - Bit 5 selects up/down counting and center-aligned channels
// - Bits 4:3 select off, bus, fixed or external clock
// - Fixed and external clocks synchronised to bus clock
// - Bits 2:0 divide selected clock by two to the field
// - Prescaler follows selection and synchronisation
// - Reading either count byte freezes both until other read
// - Read latch idles on reset, count write or control write
// - Reset clears the counter
// - Background mode halts counter and freezes read latch
// - At wrap limit: restart from zero, or count down in center mode
// - Writing one wrap byte inhibits overflow until the next write to either wrap byte
// - Reset loads wrap limit zero: free-running
// - Any write to a count byte clears the counter
// - Wrap limit zero or all ones gives full-range count
module tmc_core (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Clock sources and debug
    input wire logic fixed_system_clock,
    input wire logic external_count_clock,
    input wire logic background_mode,
    // Toward channels
    output tmc_pkg::tmc_chan_type chan,
    output logic overflow_irq
);

    tmc_pkg::tmc_state_type s_q;
    tmc_pkg::tmc_state_type s_d;

    logic access;
    logic wr;
    logic rd;
    logic tick;
    logic src_tick;
    logic at_wrap;
    logic full_range;
    logic ovf_event;
    logic mapped;
    logic [7:0] sc_read;
    logic [7:0] wbyte;

    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] b);
        hit = (a == b);
    endfunction : hit

    // Tick when the divider's low ps bits are all ones
    function automatic logic pre_due(input logic [6:0] cnt,
                                     input logic [2:0] ps);
        logic [6:0] mask;
        mask = 7'(({7'h00, 1'b1} << ps) - 8'h01);
        pre_due = ((cnt & mask) == mask);
    endfunction : pre_due

    assign access = psel && penable;
    // One wait state: read data and error are registered before ready
    assign wr = access && pwrite && s_q.ack;
    assign rd = access && !pwrite && !s_q.ack;
    assign wbyte = pwdata[7:0];
    assign pready = s_q.ack;
    assign mapped = hit(paddr, tmc_pkg::ADDR_STATUS_CONTROL)
        || hit(paddr, tmc_pkg::ADDR_COUNT_HIGH)
        || hit(paddr, tmc_pkg::ADDR_COUNT_LOW)
        || hit(paddr, tmc_pkg::ADDR_WRAP_HIGH)
        || hit(paddr, tmc_pkg::ADDR_WRAP_LOW);
    assign prdata = s_q.prdata;
    assign pslverr = s_q.pslverr;

    assign sc_read = {s_q.ovf, s_q.ovie, s_q.cas, s_q.clks, s_q.ps};

    // Source edge select after synchronising
    always_comb begin
        unique case (s_q.clks)
            tmc_pkg::CLKS_OFF: src_tick = 1'b0;
            tmc_pkg::CLKS_BUS: src_tick = 1'b1;
            tmc_pkg::CLKS_FIXED: src_tick = s_q.fix_sync[1] && !s_q.fix_prev;
            tmc_pkg::CLKS_EXT: src_tick = s_q.ext_sync[1] && !s_q.ext_prev;
        endcase
    end

    // Prescaler sits after selection
    assign tick = src_tick && !background_mode
        && pre_due(s_q.pre, s_q.ps);

    assign full_range = (s_q.wrap == tmc_pkg::WRAP_RESET)
        || (s_q.wrap == tmc_pkg::WRAP_ALL_ONES);
    assign at_wrap = full_range ? (s_q.count == tmc_pkg::WRAP_ALL_ONES)
        : (s_q.count == s_q.wrap);

    // Overflow event, masked while wrap limit is half written
    assign ovf_event = tick && at_wrap && !s_q.wrap_half
        && (s_q.cas ? !s_q.down : 1'b1);

    always_comb begin
        s_d = s_q;
        s_d.pslverr = 1'b0;
        s_d.ack = access && !s_q.ack;
        if (access && !s_q.ack && !mapped) begin
            s_d.pslverr = 1'b1;
        end

        // Two-flop synchronisers; first stage feeds only the second
        s_d.ext_sync = {s_q.ext_sync[0], external_count_clock};
        s_d.ext_prev = s_q.ext_sync[1];
        s_d.fix_sync = {s_q.fix_sync[0], fixed_system_clock};
        s_d.fix_prev = s_q.fix_sync[1];

        if (src_tick && !background_mode) begin
            s_d.pre = 7'(s_q.pre + 7'h01);
        end
        if (s_q.clks == tmc_pkg::CLKS_OFF) begin
            s_d.pre = 7'h00;
        end

        // Counter advance
        if (tick) begin
            if (!s_q.cas) begin
                s_d.down = 1'b0;
                s_d.count = at_wrap ? tmc_pkg::COUNT_RESET
                    : 16'(s_q.count + tmc_pkg::COUNT_ONE);
            end else if (s_q.down) begin
                if (s_q.count == tmc_pkg::COUNT_RESET) begin
                    s_d.down = 1'b0;
                    s_d.count = 16'(s_q.count + tmc_pkg::COUNT_ONE);
                end else begin
                    s_d.count = 16'(s_q.count - tmc_pkg::COUNT_ONE);
                end
            end else if (at_wrap) begin
                s_d.down = 1'b1;
                s_d.count = 16'(s_q.count - tmc_pkg::COUNT_ONE);
            end else begin
                s_d.count = 16'(s_q.count + tmc_pkg::COUNT_ONE);
            end
        end

        // Reads
        if (rd) begin
            s_d.prdata = 32'h0000_0000;
            if (hit(paddr, tmc_pkg::ADDR_STATUS_CONTROL)) begin
                s_d.prdata[7:0] = sc_read;
                s_d.ovf_armed = s_q.ovf;
            end else if (hit(paddr, tmc_pkg::ADDR_COUNT_HIGH)) begin
                unique case (s_q.latch)
                    tmc_pkg::LATCH_IDLE: begin
                        s_d.prdata[7:0] = s_q.count[15:8];
                        if (!background_mode) begin
                            s_d.latch_buf = s_q.count;
                            s_d.latch = tmc_pkg::LATCH_HIGH_READ;
                        end
                    end
                    tmc_pkg::LATCH_HIGH_READ: begin
                        s_d.prdata[7:0] = s_q.latch_buf[15:8];
                    end
                    tmc_pkg::LATCH_LOW_READ: begin
                        s_d.prdata[7:0] = s_q.latch_buf[15:8];
                        if (!background_mode) begin
                            s_d.latch = tmc_pkg::LATCH_IDLE;
                        end
                    end
                    default: s_d.latch = tmc_pkg::LATCH_IDLE;
                endcase
            end else if (hit(paddr, tmc_pkg::ADDR_COUNT_LOW)) begin
                unique case (s_q.latch)
                    tmc_pkg::LATCH_IDLE: begin
                        s_d.prdata[7:0] = s_q.count[7:0];
                        if (!background_mode) begin
                            s_d.latch_buf = s_q.count;
                            s_d.latch = tmc_pkg::LATCH_LOW_READ;
                        end
                    end
                    tmc_pkg::LATCH_LOW_READ: begin
                        s_d.prdata[7:0] = s_q.latch_buf[7:0];
                    end
                    tmc_pkg::LATCH_HIGH_READ: begin
                        s_d.prdata[7:0] = s_q.latch_buf[7:0];
                        if (!background_mode) begin
                            s_d.latch = tmc_pkg::LATCH_IDLE;
                        end
                    end
                    default: s_d.latch = tmc_pkg::LATCH_IDLE;
                endcase
            end else if (hit(paddr, tmc_pkg::ADDR_WRAP_HIGH)) begin
                s_d.prdata[7:0] = s_q.wrap[15:8];
            end else if (hit(paddr, tmc_pkg::ADDR_WRAP_LOW)) begin
                s_d.prdata[7:0] = s_q.wrap[7:0];
            end else begin
                s_d.pslverr = 1'b1;
            end
        end

        // Writes
        if (wr) begin
            if (hit(paddr, tmc_pkg::ADDR_STATUS_CONTROL)) begin
                s_d.ovie = wbyte[tmc_pkg::BIT_OVIE];
                s_d.cas = wbyte[tmc_pkg::BIT_CAS];
                s_d.clks = wbyte[tmc_pkg::BIT_CLKS_HI:tmc_pkg::BIT_CLKS_LO];
                s_d.ps = wbyte[tmc_pkg::BIT_PS_HI:tmc_pkg::BIT_PS_LO];
                // Zero clears only after an armed read; one is ignored
                if (!wbyte[tmc_pkg::BIT_OVF] && s_q.ovf_armed) begin
                    s_d.ovf = 1'b0;
                end
                s_d.ovf_armed = 1'b0;
                s_d.latch = tmc_pkg::LATCH_IDLE;
            end else if (hit(paddr, tmc_pkg::ADDR_COUNT_HIGH)
                || hit(paddr, tmc_pkg::ADDR_COUNT_LOW)) begin
                s_d.count = tmc_pkg::COUNT_RESET;
                s_d.down = 1'b0;
                s_d.pre = 7'h00;
                s_d.latch = tmc_pkg::LATCH_IDLE;
            end else if (hit(paddr, tmc_pkg::ADDR_WRAP_HIGH)) begin
                s_d.wrap_hold = wbyte;
                s_d.wrap_half = 1'b1;
                if (s_q.wrap_half) begin
                    s_d.wrap = {wbyte, s_q.wrap_hold};
                    s_d.wrap_half = 1'b0;
                end
            end else if (hit(paddr, tmc_pkg::ADDR_WRAP_LOW)) begin
                s_d.wrap_hold = wbyte;
                s_d.wrap_half = 1'b1;
                if (s_q.wrap_half) begin
                    s_d.wrap = {s_q.wrap_hold, wbyte};
                    s_d.wrap_half = 1'b0;
                end
            end
        end

        // New overflow wins over the clear and disarms it
        if (ovf_event) begin
            s_d.ovf = 1'b1;
            s_d.ovf_armed = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.latch <= tmc_pkg::LATCH_IDLE;
            s_q.count <= tmc_pkg::COUNT_RESET;
            s_q.wrap <= tmc_pkg::WRAP_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign overflow_irq = s_q.ovie && s_q.ovf;
    assign chan.count = s_q.count;
    assign chan.down = s_q.down;
    assign chan.tick = tick;
    assign chan.overflow = ovf_event;

endmodule : tmc_core

// [testbench/tmc_core_sva.sv]
`timescale 1ns/1ps
module tmc_core_sva (
    // Bus side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    // Counter side
    input wire logic background_mode,
    input wire tmc_pkg::tmc_chan_type chan,
    input wire logic overflow_irq
);
    logic cnt_wr;
    logic ctl_wr;
    assign cnt_wr = psel && penable && pwrite && pready && paddr inside
        {tmc_pkg::ADDR_COUNT_HIGH, tmc_pkg::ADDR_COUNT_LOW};
    assign ctl_wr = psel && penable && pwrite && pready
        && paddr == tmc_pkg::ADDR_STATUS_CONTROL;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_count_write_clear:
        assert property (cnt_wr |=> chan.count == 16'h0000)
        else $error("count not cleared by count write");
    a_tick_up_step:
        assert property (chan.tick && !chan.down && !cnt_wr |=>
            chan.count == $past(chan.count) + 16'h0001
            || chan.count == 16'h0000 || chan.down)
        else $error("up step wrong");
    a_down_step:
        assert property (chan.tick && chan.down && !cnt_wr
            && chan.count != 16'h0000 |=>
            chan.count == $past(chan.count) - 16'h0001)
        else $error("down step wrong");
    a_hold_no_tick:
        assert property (!chan.tick && !cnt_wr |=> $stable(chan.count))
        else $error("count moved without tick");
    a_bgnd_halt:
        assert property (background_mode |-> !chan.tick)
        else $error("tick during background mode");
    a_ovf_on_wrap:
        assert property (chan.overflow |-> chan.tick ##1
            (chan.count == 16'h0000 || chan.down))
        else $error("overflow not at wrap");
    a_turn_down:
        assert property ($rose(chan.down) |-> $past(chan.overflow))
        else $error("direction turned without overflow");
    a_irq_cause:
        assert property ($rose(overflow_irq) |->
            $past(chan.overflow) || $past(ctl_wr))
        else $error("interrupt rose without cause");
endmodule : tmc_core_sva

bind tmc_core tmc_core_sva u_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready),
    .background_mode(background_mode), .chan(chan),
    .overflow_irq(overflow_irq));

// [testbench/tmc_core_tb.sv]
`timescale 1ns/1ps
module tmc_core_tb;
    localparam logic [11:0] CTL = tmc_pkg::ADDR_STATUS_CONTROL;
    localparam logic [11:0] CH = tmc_pkg::ADDR_COUNT_HIGH;
    localparam logic [11:0] CL = tmc_pkg::ADDR_COUNT_LOW;
    localparam logic [11:0] WH = tmc_pkg::ADDR_WRAP_HIGH;
    localparam logic [11:0] WL = tmc_pkg::ADDR_WRAP_LOW;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic fclk, eclk, bgnd, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    tmc_pkg::tmc_chan_type chan;
    int n_fail = 0;
    int tests_run = 0;
    logic [7:0] t_ctl [6] = '{8'h18, 8'h19, 8'h1f, 8'h10, 8'h00, 8'h18};
    int t_np [6] = '{3, 5, 255, 3, 3, 3};
    int t_exp [6] = '{3, 2, 1, 3, 0, 0};
    tmc_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fixed_system_clock(fclk),
        .external_count_clock(eclk), .background_mode(bgnd),
        .chan(chan), .overflow_irq(irq));
    task automatic print_verdict;
        $display("Checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Data and error are taken at the edge where pready is seen high
    task automatic xfer(input logic [11:0] a, logic w, logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // Slow pulses: source must stay below a quarter of the bus rate
    task automatic pulse(input int n, logic fix);
        repeat (n) begin
            repeat (4) @(posedge pclk);
            if (fix)
                fclk <= 1'b1;
            else
                eclk <= 1'b1;
            repeat (4) @(posedge pclk);
            fclk <= 1'b0;
            eclk <= 1'b0;
        end
        repeat (5) @(posedge pclk);
    endtask : pulse
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        #2000000;
        n_fail++;
        print_verdict();
    end
    initial begin
        {presetn, psel, penable, pwrite, fclk, eclk, bgnd} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            xfer(12'(4 * i), 1'b0, 8'h00);
            chk("reset value", rd, 32'h0);
            chk("no error", {31'h0, err}, 32'h0);
        end
        xfer(12'h014, 1'b0, 8'h00);
        chk("unmapped", {31'h0, err}, 32'h1);
        chk("irq", {31'h0, irq}, 32'h0);
        for (int i = 0; i < 6; i++) begin
            xfer(CTL, 1'b1, t_ctl[i]);
            xfer(CH, 1'b1, 8'h5a);
            bgnd <= (i == 5);
            pulse(t_np[i], i == 3);
            bgnd <= 1'b0;
            chk("count", {16'h0, chan.count}, 32'(t_exp[i]));
        end
        xfer(CL, 1'b1, 8'h00);
        pulse(3, 1'b0);
        xfer(CH, 1'b0, 8'h00);
        pulse(2, 1'b0);
        xfer(CL, 1'b0, 8'h00);
        chk("held low", rd, 32'h3);
        xfer(CH, 1'b0, 8'h00);
        pulse(2, 1'b0);
        xfer(CTL, 1'b1, 8'h18);
        xfer(CL, 1'b0, 8'h00);
        chk("fresh low", rd, 32'h7);
        xfer(WH, 1'b1, 8'h00);
        xfer(WL, 1'b1, 8'h02);
        xfer(CH, 1'b1, 8'h00);
        pulse(2, 1'b0);
        xfer(CTL, 1'b0, 8'h00);
        chk("no flag", rd, 32'h18);
        pulse(1, 1'b0);
        chk("wrapped", {16'h0, chan.count}, 32'h0);
        xfer(CTL, 1'b0, 8'h00);
        chk("flag", rd, 32'h98);
        xfer(CTL, 1'b1, 8'h98);
        xfer(CTL, 1'b1, 8'h18);
        xfer(CTL, 1'b0, 8'h00);
        chk("no read", rd, 32'h98);
        xfer(CTL, 1'b1, 8'h18);
        xfer(CTL, 1'b0, 8'h00);
        chk("cleared", rd, 32'h18);
        xfer(WH, 1'b1, 8'h00);
        pulse(3, 1'b0);
        xfer(CTL, 1'b0, 8'h00);
        chk("pending", rd, 32'h18);
        xfer(WL, 1'b1, 8'h02);
        pulse(3, 1'b0);
        xfer(CTL, 1'b0, 8'h00);
        chk("done", rd, 32'h98);
        pulse(3, 1'b0);
        xfer(CTL, 1'b1, 8'h58);
        xfer(CTL, 1'b0, 8'h00);
        chk("restart", rd, 32'hd8);
        chk("irq on", {31'h0, irq}, 32'h1);
        xfer(CTL, 1'b1, 8'h38);
        xfer(CH, 1'b1, 8'h00);
        chk("irq off", {31'h0, irq}, 32'h0);
        pulse(3, 1'b0);
        chk("center", {16'h0, chan.count}, 32'h1);
        chk("down", {31'h0, chan.down}, 32'h1);
        xfer(CTL, 1'b0, 8'h00);
        chk("cflag", rd, 32'hb8);
        pulse(2, 1'b0);
        chk("up again", {31'h0, chan.down}, 32'h0);
        print_verdict();
    end
endmodule : tmc_core_tb
